// *** shared/cms_pkg.sv ***
// Purpose: Constants for the converter mode serial control block
// Assumes: 25 MHz system clock
// Notes:   Times in ns, cycle counts derived below
`default_nettype none
package cms_pkg;
  localparam int          CMS_CLK_NS        = 40;
  localparam int          CMS_WORD_BITS     = 8;
  localparam int          CMS_CODE_BITS     = 3;
  localparam int          CMS_CNT_BITS      = 4;
  localparam int          CMS_SAMPLE_BITS   = 8;
  localparam int          CMS_DAC_BITS      = 10;
  localparam int          CMS_T_FAST_NS     = 10000;
  localparam int          CMS_T_SLOW_NS     = 40000;
  // Longest times round down
  localparam int          CMS_T_FAST_CYC    = CMS_T_FAST_NS / CMS_CLK_NS;
  localparam int          CMS_T_SLOW_CYC    = CMS_T_SLOW_NS / CMS_CLK_NS;
  localparam int          CMS_TMR_BITS      = 11;
  localparam logic [7:0]  CMS_MODE_RESET    = 8'h00;
  localparam logic [2:0]  CMS_CODE_SHUTDOWN = 3'h0;
  localparam logic [2:0]  CMS_CODE_IDLE     = 3'h1;
  localparam logic [2:0]  CMS_CODE_RX       = 3'h2;
  localparam logic [2:0]  CMS_CODE_TX       = 3'h3;
  localparam logic [2:0]  CMS_CODE_XCVR     = 3'h4;
  localparam logic [2:0]  CMS_CODE_STANDBY  = 3'h5;
  // Power bits: reference, clock distribution, adc, dac
  localparam logic [3:0]  CMS_PWR_SHUTDOWN  = 4'h0;
  localparam logic [3:0]  CMS_PWR_IDLE      = 4'hC;
  localparam logic [3:0]  CMS_PWR_RX        = 4'hE;
  localparam logic [3:0]  CMS_PWR_TX        = 4'hD;
  localparam logic [3:0]  CMS_PWR_XCVR      = 4'hF;
  localparam logic [3:0]  CMS_PWR_STANDBY   = 4'h8;
  localparam int          CMS_PWR_REF       = 3;
  localparam int          CMS_PWR_CLKD      = 2;
  localparam int          CMS_PWR_ADC       = 1;
  localparam int          CMS_PWR_DAC       = 0;
  typedef enum logic [1:0] {CMS_WAKE_READY, CMS_WAKE_WAIT} cms_wake_t;
endpackage
`default_nettype wire

// *** rtl/cms_sync.sv ***
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Single clock domain clk
// Notes:   First stage feeds only the second
`default_nettype none
module cms_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// *** rtl/cms_shift.sv ***
// Purpose: Serial shift register, MSB first, with bit counter
// Assumes: Inputs already synchronised to clk
// Notes:   Pulses word_vld when select rises after eight or more bits
`default_nettype none
module cms_shift
  import cms_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     sck_s,
  input  wire logic                     sdi_s,
  input  wire logic                     cs_n_s,
  output var  logic [CMS_WORD_BITS-1:0] word,
  output var  logic                     word_vld
);
  logic                     sck_q_reg;
  logic                     cs_q_reg;
  logic [CMS_WORD_BITS-1:0] sh_reg;
  logic [CMS_WORD_BITS-1:0] sh_next;
  logic [CMS_CNT_BITS-1:0]  cnt_reg;
  logic [CMS_CNT_BITS-1:0]  cnt_next;
  logic                     vld_next;
  logic                     sck_rise;
  logic                     cs_rise;
  logic                     cs_fall;

  assign sck_rise = sck_s & ~sck_q_reg;
  assign cs_rise  = cs_n_s & ~cs_q_reg;
  assign cs_fall  = ~cs_n_s & cs_q_reg;

  always_comb begin
    sh_next  = sh_reg;
    cnt_next = cnt_reg;
    vld_next = 1'b0;
    if (cs_fall) begin
      cnt_next = '0;
    end else if (!cs_n_s && sck_rise && cnt_reg < CMS_CNT_BITS'(CMS_WORD_BITS)) begin
      sh_next  = {sh_reg[CMS_WORD_BITS-2:0], sdi_s};
      cnt_next = cnt_reg + 4'h1;
    end
    if (cs_rise && cnt_reg == CMS_CNT_BITS'(CMS_WORD_BITS)) begin
      vld_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q_reg <= 1'b0;
      cs_q_reg  <= 1'b1;
      sh_reg    <= '0;
      cnt_reg   <= '0;
      word_vld  <= 1'b0;
    end else begin
      sck_q_reg <= sck_s;
      cs_q_reg  <= cs_n_s;
      sh_reg    <= sh_next;
      cnt_reg   <= cnt_next;
      word_vld  <= vld_next;
    end
  end
  chk_short_frame: assert property (@(posedge clk) disable iff (!rst_n)
    cs_rise && cnt_reg != CMS_CNT_BITS'(CMS_WORD_BITS) |=> !word_vld)
    else $error("short frame produced a word");
  assign word = sh_reg;
endmodule
`default_nettype wire

// *** rtl/cms_top.sv ***
// Purpose: Mode latch and power/bus control for converter front end
// Assumes: clk 25 MHz; serial pins asynchronous to clk
// Notes:   Serial port runs in every mode
//
// Functional notes
// - Eight-bit word, low three bits matter
// - Code 000 shutdown, all off
// - Code 001 idle, reference and clock
// - Code 010 receive, adcs drive bus
// - Code 011 transmit, dacs on
// - Code 100 transceive, everything on
// - Code 101 standby, reference only
// - Serial port works in all modes
// - Bus enable shows last sample first
// - Leaving shutdown clears dac data
// - Shutdown wake 40us, receive 10us
// - Idle wake 10us with clock running
// - Idle wake 40us with clock stopped
// - Data taken only while select low
// - Rising serial clock, MSB first
// - Eight bits move word to latch
// - Serial clock idles either level
// - Wake timed from select rising
// - Active switches 10us, standby 40us, standby to receive 10us
`default_nettype none
module cms_top
  import cms_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       sck,
  input  wire logic                       sdi,
  input  wire logic                       cs_n,
  input  wire logic                       conv_clk_static,
  input  wire logic [CMS_SAMPLE_BITS-1:0] adc_sample,
  input  wire logic                       adc_sample_vld,
  input  wire logic [CMS_DAC_BITS-1:0]    dac_in,
  input  wire logic                       dac_in_vld,
  output var  logic                       ref_pwr,
  output var  logic                       clkd_pwr,
  output var  logic                       adc_pwr,
  output var  logic                       dac_pwr,
  output var  logic [CMS_SAMPLE_BITS-1:0] adc_output_bus_o,
  output var  logic                       adc_output_bus_oe_n,
  output var  logic [CMS_DAC_BITS-1:0]    dac_hold,
  output var  logic [CMS_CODE_BITS-1:0]   mode_code,
  output var  logic                       ready
);
  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [2:0] pins_s;
  logic       static_s;
  // Select enters inverted so reset reads as idle
  cms_sync #(.W(3)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({sck, sdi, ~cs_n}),
    .q     (pins_s)
  );
  cms_sync #(.W(1)) u_sync_st (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (conv_clk_static),
    .q     (static_s)
  );

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  logic [CMS_WORD_BITS-1:0] word;
  logic                     word_vld;
  cms_shift u_shift (
    .clk      (clk),
    .rst_n    (rst_n),
    .sck_s    (pins_s[2]),
    .sdi_s    (pins_s[1]),
    .cs_n_s   (~pins_s[0]),
    .word     (word),
    .word_vld (word_vld)
  );

  // ----------------------------------------
  // Mode latch and timer
  // ----------------------------------------
  function automatic logic [3:0] pwr_of(input logic [2:0] c);
    logic [3:0] p;
    p = CMS_PWR_SHUTDOWN;
    unique case (c)
      CMS_CODE_SHUTDOWN: p = CMS_PWR_SHUTDOWN;
      CMS_CODE_IDLE:     p = CMS_PWR_IDLE;
      CMS_CODE_RX:       p = CMS_PWR_RX;
      CMS_CODE_TX:       p = CMS_PWR_TX;
      CMS_CODE_XCVR:     p = CMS_PWR_XCVR;
      CMS_CODE_STANDBY:  p = CMS_PWR_STANDBY;
      default:           p = CMS_PWR_SHUTDOWN;
    endcase
    return p;
  endfunction

  function automatic logic is_active(input logic [2:0] c);
    return c == CMS_CODE_RX || c == CMS_CODE_TX || c == CMS_CODE_XCVR;
  endfunction

  logic [CMS_WORD_BITS-1:0] mode_reg;
  logic [CMS_WORD_BITS-1:0] mode_next;
  logic [CMS_TMR_BITS-1:0]  tmr_reg;
  logic [CMS_TMR_BITS-1:0]  tmr_next;
  cms_wake_t                wst_reg;
  cms_wake_t                wst_next;
  logic [2:0]               cur;
  logic [2:0]               nw;
  logic                     take;
  logic                     leave_sd;

  assign cur      = mode_reg[CMS_CODE_BITS-1:0];
  assign nw       = word[CMS_CODE_BITS-1:0];
  assign take     = word_vld && nw <= CMS_CODE_STANDBY;
  assign leave_sd = take && cur == CMS_CODE_SHUTDOWN && nw != CMS_CODE_SHUTDOWN;

  always_comb begin
    mode_next = mode_reg;
    tmr_next  = tmr_reg;
    wst_next  = wst_reg;
    if (take) begin
      mode_next = word;
      if (is_active(nw)) begin
        wst_next = CMS_WAKE_WAIT;
        if (is_active(cur)) begin
          tmr_next = CMS_TMR_BITS'(CMS_T_FAST_CYC);
        end else if (cur == CMS_CODE_IDLE) begin
          tmr_next = static_s ? CMS_TMR_BITS'(CMS_T_SLOW_CYC)
                              : CMS_TMR_BITS'(CMS_T_FAST_CYC);
        end else if (nw == CMS_CODE_RX) begin
          tmr_next = CMS_TMR_BITS'(CMS_T_FAST_CYC);
        end else begin
          // Transmit, transceive from shutdown or standby
          tmr_next = CMS_TMR_BITS'(CMS_T_SLOW_CYC);
        end
      end else begin
        wst_next = CMS_WAKE_READY;
        tmr_next = '0;
      end
    end else begin
      unique case (wst_reg)
        CMS_WAKE_WAIT: begin
          tmr_next = tmr_reg - 11'h001;
          if (tmr_reg == 11'h001) begin
            wst_next = CMS_WAKE_READY;
          end
        end
        CMS_WAKE_READY: begin
          tmr_next = tmr_reg;
        end
        default: wst_next = CMS_WAKE_READY;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= CMS_MODE_RESET;
      tmr_reg  <= '0;
      wst_reg  <= CMS_WAKE_READY;
    end else begin
      mode_reg <= mode_next;
      tmr_reg  <= tmr_next;
      wst_reg  <= wst_next;
    end
  end

  // ----------------------------------------
  // Outputs and data holding
  // ----------------------------------------
  logic [3:0]                 pw;
  logic [CMS_SAMPLE_BITS-1:0] last_reg;
  logic [CMS_SAMPLE_BITS-1:0] last_next;
  logic [CMS_DAC_BITS-1:0]    dac_next;

  assign pw = pwr_of(cur);

  always_comb begin
    last_next = last_reg;
    dac_next  = dac_hold;
    if (adc_sample_vld && pw[CMS_PWR_ADC]) begin
      last_next = adc_sample;
    end
    if (dac_in_vld && pw[CMS_PWR_DAC]) begin
      dac_next = dac_in;
    end
    if (leave_sd) begin
      dac_next = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_reg            <= '0;
      dac_hold            <= '0;
      ref_pwr             <= 1'b0;
      clkd_pwr            <= 1'b0;
      adc_pwr             <= 1'b0;
      dac_pwr             <= 1'b0;
      adc_output_bus_o    <= '0;
      adc_output_bus_oe_n <= 1'b1;
      mode_code           <= CMS_CODE_SHUTDOWN;
      ready               <= 1'b0;
    end else begin
      last_reg            <= last_next;
      dac_hold            <= dac_next;
      ref_pwr             <= pw[CMS_PWR_REF];
      clkd_pwr            <= pw[CMS_PWR_CLKD];
      adc_pwr             <= pw[CMS_PWR_ADC];
      dac_pwr             <= pw[CMS_PWR_DAC];
      adc_output_bus_o    <= last_next;
      adc_output_bus_oe_n <= ~pw[CMS_PWR_ADC];
      mode_code           <= cur;
      ready               <= wst_next == CMS_WAKE_READY && is_active(mode_next[2:0]);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_bus_tristate: assert property (@(posedge clk) disable iff (!rst_n)
    !adc_pwr |-> adc_output_bus_oe_n)
    else $error("adc bus driven while adcs off");
  chk_rx_decode: assert property (@(posedge clk) disable iff (!rst_n)
    $past(cur) == CMS_CODE_RX |-> !adc_output_bus_oe_n && !dac_pwr && ref_pwr)
    else $error("receive decode wrong");
  chk_xcvr_decode: assert property (@(posedge clk) disable iff (!rst_n)
    $past(cur) == CMS_CODE_XCVR |-> adc_pwr && dac_pwr && ref_pwr)
    else $error("transceive decode wrong");
  chk_standby_decode: assert property (@(posedge clk) disable iff (!rst_n)
    $past(cur) == CMS_CODE_STANDBY |-> ref_pwr && !clkd_pwr && !adc_pwr && !dac_pwr)
    else $error("standby decode wrong");
  chk_reserved_code: assert property (@(posedge clk) disable iff (!rst_n)
    word_vld && nw > CMS_CODE_STANDBY |=> $stable(mode_reg))
    else $error("reserved code changed mode");
  chk_word_latch: assert property (@(posedge clk) disable iff (!rst_n)
    take |=> mode_reg == $past(word))
    else $error("word not latched");
  chk_dac_clear: assert property (@(posedge clk) disable iff (!rst_n)
    leave_sd |=> dac_hold == '0)
    else $error("dac data kept after shutdown");
  chk_fast_wake: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_active(nw) && is_active(cur) |=> tmr_reg == CMS_TMR_BITS'(CMS_T_FAST_CYC))
    else $error("active switch time wrong");
  chk_bus_sample: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(adc_output_bus_oe_n) |-> adc_output_bus_o == last_reg)
    else $error("bus enabled without last sample");
  chk_shutdown_decode: assert property (@(posedge clk) disable iff (!rst_n)
    $past(cur) == CMS_CODE_SHUTDOWN |-> !ref_pwr && !clkd_pwr && !adc_pwr && !dac_pwr)
    else $error("shutdown decode wrong");
  chk_idle_decode: assert property (@(posedge clk) disable iff (!rst_n)
    $past(cur) == CMS_CODE_IDLE |-> ref_pwr && clkd_pwr && !adc_pwr && !dac_pwr)
    else $error("idle decode wrong");
  chk_tx_decode: assert property (@(posedge clk) disable iff (!rst_n)
    $past(cur) == CMS_CODE_TX |-> ref_pwr && dac_pwr && !adc_pwr && adc_output_bus_oe_n)
    else $error("transmit decode wrong");
  chk_slow_wake: assert property (@(posedge clk) disable iff (!rst_n)
    take && nw != CMS_CODE_RX && is_active(nw) &&
    (cur == CMS_CODE_SHUTDOWN || cur == CMS_CODE_STANDBY)
    |=> tmr_reg == CMS_TMR_BITS'(CMS_T_SLOW_CYC))
    else $error("wake from shutdown time wrong");
  chk_idle_static: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_active(nw) && cur == CMS_CODE_IDLE && static_s
    |=> tmr_reg == CMS_TMR_BITS'(CMS_T_SLOW_CYC))
    else $error("idle wake with stopped clock wrong");
  chk_wait_after_latch: assert property (@(posedge clk) disable iff (!rst_n)
    take && is_active(nw) |=> !ready)
    else $error("ready before wake time");
  chk_ready_mode: assert property (@(posedge clk) disable iff (!rst_n)
    ready |-> is_active(mode_code))
    else $error("ready outside active mode");
  chk_port_alive: assert property (@(posedge clk) disable iff (!rst_n)
    word_vld && nw <= CMS_CODE_STANDBY |=> cur == $past(nw))
    else $error("word refused in current mode");
  cov_rx: cover property (@(posedge clk) disable iff (!rst_n) take && nw == CMS_CODE_RX);
  cov_xcvr: cover property (@(posedge clk) disable iff (!rst_n) take && nw == CMS_CODE_XCVR);
  cov_ready: cover property (@(posedge clk) disable iff (!rst_n) $rose(ready));
  cov_bad: cover property (@(posedge clk) disable iff (!rst_n) word_vld && !take);
  cov_idle_slow: cover property (@(posedge clk) disable iff (!rst_n) take && static_s);
endmodule
`default_nettype wire

// *** sim/cms_host_model.sv ***
// Purpose: Host model that writes mode words over the 3-wire port
// Assumes: Serial clock period 320 ns, unrelated in phase to clk
// Notes:   Serial clock rests at idle_hi outside frames
`default_nettype none
module cms_host_model (
  input  wire logic       start,
  input  wire logic [7:0] word,
  input  wire logic [3:0] nbits,
  input  wire logic       idle_hi,
  output var  logic       sck,
  output var  logic       sdi,
  output var  logic       cs_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------
  // Frame generator
  // ----------------------------------------
  initial begin
    sck  = 1'b0;
    sdi  = 1'b0;
    cs_n = 1'b1;
  end

  // select, msb first, idle level, gap
  always @(posedge start) begin
    sck = idle_hi;
    #7;
    cs_n = 1'b0;
    #160;
    for (int i = 0; i < nbits; i++) begin
      sck = 1'b0;
      sdi = word[7-i];
      #160;
      sck = 1'b1;
      #160;
    end
    sck = idle_hi;
    #160;
    cs_n = 1'b1;
    // No pull on data line once released
    sdi = ~sdi;
  end
endmodule
`default_nettype wire

// *** sim/cms_top_tb.sv ***
// Purpose: Self-checking bench for the mode latch and power control
// Assumes: clk 25 MHz, inputs driven on falling edge
// Notes:   Table of writes with expected mode, power and wake time
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); \
    end \
  end
module cms_top_tb
  import cms_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                       clk, rst_n, conv_clk_static, adc_sample_vld, dac_in_vld;
  logic [CMS_SAMPLE_BITS-1:0] adc_sample, adc_output_bus_o;
  logic [CMS_DAC_BITS-1:0]    dac_in, dac_hold;
  logic                       sck, sdi, cs_n, h_start, h_pol;
  logic [7:0]                 h_word;
  logic [3:0]                 h_nbits;
  logic                       ref_pwr, clkd_pwr, adc_pwr, dac_pwr, adc_output_bus_oe_n, ready;
  logic [CMS_CODE_BITS-1:0]   mode_code;
  int                         miscompares = 0;
  int                         compares = 0;
  logic [7:0]                 t_word [0:14] = '{8'hFA, 8'h03, 8'h04, 8'h00, 8'h03, 8'h05,
                                  8'h04, 8'h01, 8'h02, 8'h01, 8'h0B, 8'h04, 8'h06, 8'h07, 8'h1C};
  logic [2:0]                 t_code [0:14] = '{3'h2, 3'h3, 3'h4, 3'h0, 3'h3, 3'h5,
                                  3'h4, 3'h1, 3'h2, 3'h1, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4};
  int                         t_wait [0:14] = '{250, 250, 250, 1100, 1000, 1100, 1000,
                                  1100, 1000, 1100, 250, 12, 12, 12, 250};

  // ----------------------------------------
  // Instances and clock
  // ----------------------------------------
  cms_host_model cms_host_model_inst (
    .start   (h_start),
    .word    (h_word),
    .nbits   (h_nbits),
    .idle_hi (h_pol),
    .sck     (sck),
    .sdi     (sdi),
    .cs_n    (cs_n)
  );

  cms_top cms_top_inst (
    .clk                 (clk),
    .rst_n               (rst_n),
    .sck                 (sck),
    .sdi                 (sdi),
    .cs_n                (cs_n),
    .conv_clk_static     (conv_clk_static),
    .adc_sample          (adc_sample),
    .adc_sample_vld      (adc_sample_vld),
    .dac_in              (dac_in),
    .dac_in_vld          (dac_in_vld),
    .ref_pwr             (ref_pwr),
    .clkd_pwr            (clkd_pwr),
    .adc_pwr             (adc_pwr),
    .dac_pwr             (dac_pwr),
    .adc_output_bus_o    (adc_output_bus_o),
    .adc_output_bus_oe_n (adc_output_bus_oe_n),
    .dac_hold            (dac_hold),
    .mode_code           (mode_code),
    .ready               (ready)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [3:0] pwr_of(input logic [2:0] c);
    case (c)
      CMS_CODE_IDLE:    return CMS_PWR_IDLE;
      CMS_CODE_RX:      return CMS_PWR_RX;
      CMS_CODE_TX:      return CMS_PWR_TX;
      CMS_CODE_XCVR:    return CMS_PWR_XCVR;
      CMS_CODE_STANDBY: return CMS_PWR_STANDBY;
      default:          return CMS_PWR_SHUTDOWN;
    endcase
  endfunction

  // Cycles from select rising until ready rises; ready may first drop
  task automatic run(input logic [7:0] w, input logic [3:0] n, input logic pol,
                     output int cyc);
    cyc = 0;
    @(negedge clk);
    h_word  = w;
    h_nbits = n;
    h_pol   = pol;
    h_start = 1'b1;
    @(negedge clk);
    h_start = 1'b0;
    @(posedge cs_n);
    while (ready === 1'b1 && cyc < 12) begin
      @(negedge clk);
      cyc++;
    end
    while (ready !== 1'b1 && cyc < 1100) begin
      @(negedge clk);
      cyc++;
    end
  endtask

  task automatic pulse(input logic [7:0] a, input logic [9:0] d);
    @(negedge clk);
    adc_sample     = a;
    dac_in         = d;
    adc_sample_vld = 1'b1;
    dac_in_vld     = 1'b1;
    @(negedge clk);
    adc_sample_vld = 1'b0;
    dac_in_vld     = 1'b0;
    dac_in         = 10'h000;
    repeat (4) @(negedge clk);
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    int         cyc;
    logic [3:0] p;
    rst_n = 1'b0;
    conv_clk_static = 1'b0;
    adc_sample = 8'h00;
    adc_sample_vld = 1'b0;
    dac_in = 10'h000;
    dac_in_vld = 1'b0;
    h_start = 1'b0;
    h_word = 8'h00;
    h_nbits = 4'h8;
    h_pol = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    `CHK("reset state", 6'h02, {ref_pwr, clkd_pwr, adc_pwr, dac_pwr, adc_output_bus_oe_n, ready});
    `CHK("reset mode", 3'h0, mode_code);
    for (int i = 0; i < 15; i++) begin
      @(negedge clk);
      conv_clk_static = (i == 7 || i == 8);
      run(t_word[i], (i == 11) ? 4'h7 : 4'h8, i[0], cyc);
      p = pwr_of(t_code[i]);
      `CHK("wake time", 1'b1, (cyc >= t_wait[i] && cyc <= t_wait[i] + 10));
      `CHK("mode", t_code[i], mode_code);
      `CHK("power", p, {ref_pwr, clkd_pwr, adc_pwr, dac_pwr});
      `CHK("bus enable", ~p[CMS_PWR_ADC], adc_output_bus_oe_n);
      if (i == 0) begin
        pulse(8'h5A, 10'h000);
        `CHK("adc bus", 8'h5A, adc_output_bus_o);
      end
      if (i == 1) begin
        pulse(8'hC3, 10'h2C7);
        `CHK("dac hold", 10'h2C7, dac_hold);
      end
      if (i == 4) `CHK("dac cleared", 10'h000, dac_hold);
      if (i == 8) `CHK("adc bus", 8'h5A, adc_output_bus_o);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
